// ===== dpr_ram_top.sv
// Dual-port RAM with initial contents, port widths and write modes
//
// Functional notes
// - Cells hold zero after loading unless a vector gives another value.
// - Data contents come from 64 vectors of 256 bits each.
// - Missing or short vectors are padded with zeros.
// - Vector yy fills cells yy*256 upward, its bit 0 lowest.
// - Eight parity vectors fill parity cells the same way.
// - After loading, output latches show the port's initial value.
// - Synchronous clear loads the port's clear value into the latches.
// - Synchronous clear is unavailable while the output pipe is on.
// - Initial and clear values follow port width; top bits are parity.
// - Each port has zero or one output pipe stage, default zero.
// - Pipe stage may capture on the inverted clock, default not.
// - Cascade half is upper, lower or none per port.
// - Read width per port is 0,1,2,4,9,18 or 36, default 0.
// - Write width per port likewise, set apart from read width.
// - Write modes: show new, show old, or hold output.
// - Every port has a 15-bit address that the user drives.
// - Every port has four write enables, one per byte lane.
// - Ports carry 32 data and 4 parity bits each way.
// - Hold mode keeps outputs during writes; others show new or old.
// - Clear acts only on enabled edges and leaves cells alone.
// - Global clear restores output initial values, cells untouched.
`timescale 1ns/1ps
module dpr_ram_top #(
	parameter int                     READ_WIDTH_A   = 0,
	parameter int                     READ_WIDTH_B   = 0,
	parameter int                     WRITE_WIDTH_A  = 0,
	parameter int                     WRITE_WIDTH_B  = 0,
	parameter bit                     OUT_PIPE_A     = 1'b0,
	parameter bit                     OUT_PIPE_B     = 1'b0,
	parameter bit                     INV_PIPE_CLK_A = 1'b0,
	parameter bit                     INV_PIPE_CLK_B = 1'b0,
	parameter dpr_pkg::dpr_wmode_type WRITE_MODE_A   = dpr_pkg::WR_SHOW_NEW,
	parameter dpr_pkg::dpr_wmode_type WRITE_MODE_B   = dpr_pkg::WR_SHOW_NEW,
	parameter dpr_pkg::dpr_half_type  CASCADE_HALF_SELECT_A =
		dpr_pkg::HALF_NONE,
	parameter dpr_pkg::dpr_half_type  CASCADE_HALF_SELECT_B =
		dpr_pkg::HALF_NONE,
	parameter logic [35:0]            OUT_INIT_VALUE_A   = 36'h000000000,
	parameter logic [35:0]            OUT_INIT_VALUE_B   = 36'h000000000,
	parameter logic [35:0]            SYNC_CLEAR_VALUE_A = 36'h000000000,
	parameter logic [35:0]            SYNC_CLEAR_VALUE_B = 36'h000000000,
	parameter logic [63:0][255:0]     CONTENT_INIT_VECTOR = '0,
	parameter logic [7:0][255:0]      PARITY_INIT_VECTOR  = '0
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset,
	input  wire logic        i_clk_en,
	input  wire logic        i_global_set_clear,
	input  wire logic        i_en_a,
	input  wire logic [3:0]  i_we_a,
	input  wire logic [14:0] i_addr_a,
	input  wire logic [31:0] i_data_a,
	input  wire logic [3:0]  i_parity_in_bus_a,
	input  wire logic        i_sync_set_clear_a,
	input  wire logic        i_output_pipe_clock_enable_a,
	input  wire logic        i_chain_input_a,
	output logic [31:0]      o_data_a,
	output logic [3:0]       o_parity_out_bus_a,
	output logic             o_chain_output_a,
	input  wire logic        i_en_b,
	input  wire logic [3:0]  i_we_b,
	input  wire logic [14:0] i_addr_b,
	input  wire logic [31:0] i_data_b,
	input  wire logic [3:0]  i_parity_in_bus_b,
	input  wire logic        i_sync_set_clear_b,
	input  wire logic        i_output_pipe_clock_enable_b,
	input  wire logic        i_chain_input_b,
	output logic [31:0]      o_data_b,
	output logic [3:0]       o_parity_out_bus_b,
	output logic             o_chain_output_b,
	output logic             o_init_done
);
	localparam int RD_W [2] = '{READ_WIDTH_A, READ_WIDTH_B};
	localparam int WR_W [2] = '{WRITE_WIDTH_A, WRITE_WIDTH_B};
	localparam dpr_pkg::dpr_half_type HALF [2] =
		'{CASCADE_HALF_SELECT_A, CASCADE_HALF_SELECT_B};

	// Settings the array cannot serve are refused at elaboration
	for (genvar p = 0; p < 2; p++) begin : g_check
		if (!dpr_pkg::width_ok(RD_W[p]) || !dpr_pkg::width_ok(WR_W[p]))
			$error("unsupported port width");
		if (HALF[p] != dpr_pkg::HALF_NONE && (RD_W[p] > 1 || WR_W[p] > 1))
			$error("cascade needs one-bit widths");
	end

	// Storage: 64 rows of data cells, 8 rows of parity cells
	logic [255:0]          data_rows_q [dpr_pkg::DATA_ROWS];
	logic [255:0]          par_rows_q  [dpr_pkg::PAR_ROWS];
	dpr_pkg::dpr_load_type load_st_q;
	logic [6:0]            load_cnt_q;
	logic                  ready;

	// Per-port views of the user inputs
	logic                  p_en     [2];
	logic [3:0]            p_we     [2];
	logic [14:0]           p_addr   [2];
	logic [35:0]           p_din    [2];
	logic                  p_ssr    [2];
	logic                  p_output_pipe_clock_enable  [2];
	logic                  p_chain  [2];
	logic [1:0]            wr_act;
	logic [13:0]           wd_start [2];
	logic [10:0]           wp_start [2];
	logic [13:0]           rd_start [2];
	logic [10:0]           rp_start [2];
	logic [35:0]           old_w    [2];
	logic [35:0]           new_w    [2];

	dpr_port_if pif [2] ();

	function automatic logic [5:0] row_of(input logic [13:0] c);
		return c[13:8];
	endfunction : row_of

	function automatic logic [2:0] prow_of(input logic [10:0] c);
		return c[10:8];
	endfunction : prow_of

	// Byte lane that owns a given data bit of the written word
	function automatic logic [1:0] lane_of(input logic [13:0] off);
		return off[4:3];
	endfunction : lane_of

	assign p_en    = '{i_en_a, i_en_b};
	assign p_we    = '{i_we_a, i_we_b};
	assign p_addr  = '{i_addr_a, i_addr_b};
	assign p_din   = '{{i_parity_in_bus_a, i_data_a},
		{i_parity_in_bus_b, i_data_b}};
	assign p_ssr   = '{i_sync_set_clear_a, i_sync_set_clear_b};
	assign p_output_pipe_clock_enable = '{i_output_pipe_clock_enable_a,
		i_output_pipe_clock_enable_b};
	assign p_chain = '{i_chain_input_a, i_chain_input_b};

	// Ports stay closed until every vector is in place
	assign ready       = (load_st_q == dpr_pkg::LD_RUN);
	assign o_init_done = ready;

	// Loader walks data rows then parity rows, one per cycle
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			load_st_q  <= dpr_pkg::LD_FILL;
			load_cnt_q <= 7'h00;
		end else if (i_clk_en) begin
			unique case (load_st_q)
				dpr_pkg::LD_FILL: begin
					load_cnt_q <= load_cnt_q + 7'h01;
					if (load_cnt_q == 7'(dpr_pkg::LOAD_STEPS - 1))
						load_st_q <= dpr_pkg::LD_RUN;
				end
				dpr_pkg::LD_RUN: load_st_q <= dpr_pkg::LD_RUN;
			endcase
		end
	end

	for (genvar p = 0; p < 2; p++) begin : g_port
		localparam int RDB = dpr_pkg::data_bits(RD_W[p]);
		localparam int RPB = dpr_pkg::par_bits(RD_W[p]);
		localparam int WDB = dpr_pkg::data_bits(WR_W[p]);
		localparam int WPB = dpr_pkg::par_bits(WR_W[p]);
		localparam int RSH = $clog2(RDB);
		localparam int WSH = $clog2(WDB);
		logic casc_ok;

		// Cascade halves accept writes only in their own address half
		assign casc_ok = (HALF[p] == dpr_pkg::HALF_NONE) ||
			(p_addr[p][dpr_pkg::CASC_BIT] ==
			(HALF[p] == dpr_pkg::HALF_UPPER));

		// Cell ranges follow the width: start = index * data or parity bits per word
		assign rd_start[p] = 14'((p_addr[p][13:0] >> RSH) * RDB);
		assign rp_start[p] = 11'((p_addr[p][13:0] >> RSH) * RPB);
		assign wd_start[p] = 14'((p_addr[p][13:0] >> WSH) * WDB);
		assign wp_start[p] = 11'((p_addr[p][13:0] >> WSH) * WPB);
		assign wr_act[p]   = ready && p_en[p] && (|p_we[p]) &&
			(WR_W[p] != 0) && casc_ok;

		// Stored word, and the word as it reads after this write
		always_comb begin
			logic [13:0] c;
			logic [13:0] o;
			logic [10:0] pc;
			logic [10:0] q;
			c        = 14'h0000;
			o        = 14'h0000;
			pc       = 11'h000;
			q        = 11'h000;
			old_w[p] = dpr_pkg::ZERO_WORD;
			new_w[p] = dpr_pkg::ZERO_WORD;
			for (int j = 0; j < dpr_pkg::DATA_W; j++) begin
				if (j < RDB) begin
					c = rd_start[p] + 14'(j);
					o = c - wd_start[p];
					old_w[p][j] = data_rows_q[row_of(c)][c[7:0]];
					new_w[p][j] = (wr_act[p] && o < 14'(WDB) &&
						p_we[p][lane_of(o)]) ? p_din[p][o[4:0]] :
						old_w[p][j];
				end
			end
			for (int j = 0; j < dpr_pkg::PAR_W; j++) begin
				if (j < RPB) begin
					pc = rp_start[p] + 11'(j);
					q  = pc - wp_start[p];
					old_w[p][dpr_pkg::DATA_W + j] =
						par_rows_q[prow_of(pc)][pc[7:0]];
					new_w[p][dpr_pkg::DATA_W + j] = (wr_act[p] &&
						q < 11'(WPB) && p_we[p][q[1:0]]) ?
						p_din[p][dpr_pkg::DATA_W + 32'(q[1:0])] :
						old_w[p][dpr_pkg::DATA_W + j];
				end
			end
			// Upper half reads the lower block's bit on its low half
			if (HALF[p] == dpr_pkg::HALF_UPPER &&
				!p_addr[p][dpr_pkg::CASC_BIT]) begin
				old_w[p][0] = p_chain[p];
				new_w[p][0] = p_chain[p];
			end
		end

		assign pif[p].ready    = ready;
		assign pif[p].en       = p_en[p];
		assign pif[p].sync_set_clear_input      = p_ssr[p];
		assign pif[p].output_pipe_clock_enable    = p_output_pipe_clock_enable[p];
		assign pif[p].wr       = wr_act[p];
		assign pif[p].old_word = old_w[p];
		assign pif[p].new_word = new_w[p];
	end

	// Memory: loading first, then user writes; port B wins a clash
	always_ff @(posedge i_clk_sys) begin
		if (!i_reset && i_clk_en) begin
			if (load_st_q == dpr_pkg::LD_FILL) begin
				if (load_cnt_q < 7'(dpr_pkg::DATA_ROWS))
					data_rows_q[load_cnt_q[5:0]] <=
						CONTENT_INIT_VECTOR[load_cnt_q[5:0]];
				else
					par_rows_q[load_cnt_q[2:0]] <=
						PARITY_INIT_VECTOR[load_cnt_q[2:0]];
			end else begin
				for (int p = 0; p < 2; p++) begin
					for (int j = 0; j < dpr_pkg::DATA_W; j++) begin
						if (wr_act[p] && j < dpr_pkg::data_bits(WR_W[p]) &&
							p_we[p][j >> dpr_pkg::LANE_SHIFT])
							data_rows_q[row_of(wd_start[p] + 14'(j))]
								[8'(wd_start[p] + 14'(j))] <= p_din[p][j];
					end
					for (int j = 0; j < dpr_pkg::PAR_W; j++) begin
						if (wr_act[p] && j < dpr_pkg::par_bits(WR_W[p]) &&
							p_we[p][j])
							par_rows_q[prow_of(wp_start[p] + 11'(j))]
								[8'(wp_start[p] + 11'(j))] <=
								p_din[p][dpr_pkg::DATA_W + j];
					end
				end
			end
		end
	end

	// Output stages hold latches, clear values and pipes
	dpr_port_out #(
		.PIPE      (OUT_PIPE_A),
		.INV_CLK   (INV_PIPE_CLK_A),
		.WMODE     (WRITE_MODE_A),
		.RD_W      (READ_WIDTH_A),
		.WR_W      (WRITE_WIDTH_A),
		.INIT_VAL  (OUT_INIT_VALUE_A),
		.CLEAR_VAL (SYNC_CLEAR_VALUE_A)
	) u_out_a (
		.i_clk_sys          (i_clk_sys),
		.i_reset            (i_reset),
		.i_clk_en           (i_clk_en),
		.i_global_set_clear (i_global_set_clear),
		.pif                (pif[0])
	);

	dpr_port_out #(
		.PIPE      (OUT_PIPE_B),
		.INV_CLK   (INV_PIPE_CLK_B),
		.WMODE     (WRITE_MODE_B),
		.RD_W      (READ_WIDTH_B),
		.WR_W      (WRITE_WIDTH_B),
		.INIT_VAL  (OUT_INIT_VALUE_B),
		.CLEAR_VAL (SYNC_CLEAR_VALUE_B)
	) u_out_b (
		.i_clk_sys          (i_clk_sys),
		.i_reset            (i_reset),
		.i_clk_en           (i_clk_en),
		.i_global_set_clear (i_global_set_clear),
		.pif                (pif[1])
	);

	assign o_data_a           = pif[0].out_word[31:0];
	assign o_parity_out_bus_a = pif[0].out_word[35:32];
	assign o_data_b           = pif[1].out_word[31:0];
	assign o_parity_out_bus_b = pif[1].out_word[35:32];

	// Lower half passes its raw cell to the upper block, same cycle
	assign o_chain_output_a = (HALF[0] == dpr_pkg::HALF_LOWER) ?
		old_w[0][0] : 1'b0;
	assign o_chain_output_b = (HALF[1] == dpr_pkg::HALF_LOWER) ?
		old_w[1][0] : 1'b0;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	a_no_early_access: assert property (ready |->
		load_cnt_q == 7'(dpr_pkg::LOAD_STEPS)) else $error("opened early");
	a_loader_steps: assert property (
		!i_reset && load_st_q == dpr_pkg::LD_FILL && i_clk_en
		|=> load_cnt_q == 7'($past(load_cnt_q) + 7'h01))
		else $error("loader skipped a row");
	a_rows_loaded: assert property (
		$rose(ready) |-> data_rows_q[0] == CONTENT_INIT_VECTOR[0] &&
		data_rows_q[63] == CONTENT_INIT_VECTOR[63] &&
		par_rows_q[7] == PARITY_INIT_VECTOR[7])
		else $error("initial contents wrong");
	a_write_lands: assert property (
		wr_act[0] && !wr_act[1] && i_clk_en && p_we[0][0] &&
		WRITE_WIDTH_A != 0 |=> data_rows_q[row_of($past(wd_start[0]))]
		[8'($past(wd_start[0]))] == $past(p_din[0][0]))
		else $error("write did not reach cell");
endmodule : dpr_ram_top

// ===== dpr_pkg.sv
// Shared constants, types and helpers of the dual-port RAM block
package dpr_pkg;
	localparam int ROW_BITS   = 256;
	localparam int DATA_ROWS  = 64;
	localparam int PAR_ROWS   = 8;
	localparam int LOAD_STEPS = DATA_ROWS + PAR_ROWS;
	localparam int ADDR_W     = 15;
	localparam int DATA_W     = 32;
	localparam int PAR_W      = 4;
	localparam int WORD_W     = DATA_W + PAR_W;
	localparam int LANE_SHIFT = 3;
	localparam int CASC_BIT   = 14;
	localparam int BYTE_W     = 9;
	localparam logic [WORD_W-1:0] ZERO_WORD = 36'h000000000;

	typedef enum {WR_SHOW_NEW, WR_SHOW_OLD, WR_HOLD} dpr_wmode_type;
	typedef enum {HALF_NONE, HALF_UPPER, HALF_LOWER} dpr_half_type;
	typedef enum {LD_FILL, LD_RUN} dpr_load_type;

	// Regular data bits carried by a port width
	function automatic int data_bits(input int w);
		return (w >= BYTE_W) ? (w / BYTE_W) * 8 : w;
	endfunction : data_bits

	// Parity bits carried by a port width
	function automatic int par_bits(input int w);
		return (w >= BYTE_W) ? w / BYTE_W : 0;
	endfunction : par_bits

	function automatic bit width_ok(input int w);
		return w inside {0, 1, 2, 4, 9, 18, 36};
	endfunction : width_ok

	// Place a port-width value on the data and parity lanes
	function automatic logic [WORD_W-1:0] spread(
		input logic [WORD_W-1:0] v, input int w);
		logic [WORD_W-1:0] r;
		int                d;
		r = ZERO_WORD;
		d = data_bits(w);
		for (int i = 0; i < DATA_W; i++)
			if (i < d) r[i] = v[i];
		for (int i = 0; i < PAR_W; i++)
			if (i < par_bits(w)) r[DATA_W + i] = v[d + i];
		return r;
	endfunction : spread
endpackage : dpr_pkg

// ===== dpr_port_if.sv
// Carrier between the RAM core and one output stage
`timescale 1ns/1ps
interface dpr_port_if;
	logic        ready;
	logic        en;
	logic        sync_set_clear_input;
	logic        output_pipe_clock_enable;
	logic        wr;
	logic [35:0] old_word;
	logic [35:0] new_word;
	logic [35:0] out_word;
	modport core (output ready, en, sync_set_clear_input, output_pipe_clock_enable, wr, old_word, new_word,
		input out_word);
	modport stage (input ready, en, sync_set_clear_input, output_pipe_clock_enable, wr, old_word, new_word,
		output out_word);
endinterface : dpr_port_if

// ===== dpr_port_out.sv
// Output latch, synchronous clear and optional pipe of one port
`timescale 1ns/1ps
module dpr_port_out #(
	parameter bit                     PIPE      = 1'b0,
	parameter bit                     INV_CLK   = 1'b0,
	parameter dpr_pkg::dpr_wmode_type WMODE     = dpr_pkg::WR_SHOW_NEW,
	parameter int                     RD_W      = 0,
	parameter int                     WR_W      = 0,
	parameter logic [35:0]            INIT_VAL  = 36'h000000000,
	parameter logic [35:0]            CLEAR_VAL = 36'h000000000
) (
	input  wire logic   i_clk_sys,
	input  wire logic   i_reset,
	input  wire logic   i_clk_en,
	input  wire logic   i_global_set_clear,
	dpr_port_if.stage   pif
);
	localparam logic [35:0] INIT_W  = dpr_pkg::spread(INIT_VAL, RD_W);
	localparam logic [35:0] CLEAR_W = dpr_pkg::spread(CLEAR_VAL, RD_W);
	localparam bit          UNUSED  = (RD_W == 0) && (WR_W == 0);

	logic [35:0] latch_q;
	logic [35:0] pipe_q;
	logic        live;

	assign live = i_clk_en && pif.ready && !UNUSED && pif.en;

	// Output latches; clear is ignored once the pipe is in use
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || i_global_set_clear) begin
			latch_q <= INIT_W;
		end else if (live) begin
			if (pif.sync_set_clear_input && !PIPE) begin
				latch_q <= CLEAR_W;
			end else if (!pif.wr) begin
				latch_q <= pif.old_word;
			end else begin
				unique case (WMODE)
					dpr_pkg::WR_SHOW_NEW: latch_q <= pif.new_word;
					dpr_pkg::WR_SHOW_OLD: latch_q <= pif.old_word;
					dpr_pkg::WR_HOLD:     latch_q <= latch_q;
				endcase
			end
		end
	end

	// Pipe stage, on the falling edge when inverted
	if (INV_CLK) begin : g_neg
		always_ff @(negedge i_clk_sys) begin
			if (i_reset || i_global_set_clear) pipe_q <= INIT_W;
			else if (i_clk_en && pif.output_pipe_clock_enable) pipe_q <= latch_q;
		end
	end else begin : g_pos
		always_ff @(posedge i_clk_sys) begin
			if (i_reset || i_global_set_clear) pipe_q <= INIT_W;
			else if (i_clk_en && pif.output_pipe_clock_enable) pipe_q <= latch_q;
		end
	end

	assign pif.out_word = PIPE ? pipe_q : latch_q;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	a_clear_takes_value: assert property (
		live && pif.sync_set_clear_input && !PIPE && !i_global_set_clear
		|=> latch_q == CLEAR_W) else $error("clear value not loaded");
	a_disabled_port_holds: assert property (
		!pif.en && !i_global_set_clear |=> $stable(latch_q))
		else $error("latch moved while disabled");
	a_hold_on_write: assert property (
		live && pif.wr && !(pif.sync_set_clear_input && !PIPE) && !i_global_set_clear
		&& WMODE == dpr_pkg::WR_HOLD |=> $stable(latch_q))
		else $error("output changed in hold mode");
	a_show_new_word: assert property (
		live && pif.wr && !(pif.sync_set_clear_input && !PIPE) && !i_global_set_clear
		&& WMODE == dpr_pkg::WR_SHOW_NEW
		|=> latch_q == $past(pif.new_word))
		else $error("new data not shown");
	a_global_restores: assert property (
		i_global_set_clear |=> latch_q == INIT_W && pipe_q == INIT_W)
		else $error("global clear missed");
	a_unused_idle: assert property (
		UNUSED |-> latch_q == INIT_W) else $error("unused port moved");
endmodule : dpr_port_out

// ===== dpr_fabric.sv
// Behavioural user-fabric driver for one RAM port
`timescale 1ns/1ps
module dpr_fabric #(
	parameter int SHIFT  = 5,
	parameter bit PAIR18 = 1'b0
) (
	input  wire logic   i_clk_sys,
	output logic        o_en,
	output logic [3:0]  o_we,
	output logic [14:0] o_addr,
	output logic [31:0] o_data,
	output logic [3:0]  o_par,
	output logic        o_ssr
);
	// Idle levels at time zero
	initial begin
		o_en   = 1'b0;
		o_we   = 4'h0;
		o_addr = 15'h7FFF;
		o_data = 32'hFFFFFFFF;
		o_par  = 4'hF;
		o_ssr  = 1'b0;
	end

	// Hold a request over one edge; released data lines show the inverse
	task automatic op(input logic en, input logic [3:0] we, input int idx,
		input logic [31:0] d, input logic [3:0] p, input logic sync_set_clear_input);
		logic [13:0] a;
		a = 14'(idx << SHIFT);
		@(posedge i_clk_sys);
		o_en   <= en;
		o_we   <= PAIR18 ? {we[1], we[0], we[1], we[0]} : we;
		o_addr <= {1'b1, a};
		o_data <= d;
		o_par  <= p;
		o_ssr  <= sync_set_clear_input;
		@(posedge i_clk_sys);
		o_en   <= 1'b0;
		o_we   <= 4'h0;
		o_ssr  <= 1'b0;
		o_data <= ~d;
		o_par  <= ~p;
	endtask : op
endmodule : dpr_fabric

// ===== tb.sv
// Self-checking bench of the dual-port RAM block
`timescale 1ns/1ps
module tb;
	localparam logic [63:0][255:0] CIV = '{0: {8{32'h0123_4567}},
		31: 256'hA5C3, 63: {4{64'hF00D_CAFE_1234_5678}}, default: '0};
	localparam logic [7:0][255:0]  PIV = '{0: {8{32'h89AB_CDEF}},
		7: 256'h3, default: '0};
	localparam logic [35:0] INIT_A  = 36'h987654321;
	localparam logic [35:0] INIT_B  = 36'h000025A5C;
	localparam logic [35:0] CLEAR_A = 36'h50F0F1E1E;
	localparam int          WA      = 36;
	localparam int          WB      = 18;
	localparam int          SH_A    = 5;
	localparam int          SH_B    = 4;
	localparam bit          PAIR_A  = 1'b0;
	localparam bit          PAIR_B  = 1'b1;
	logic           clk_sys, reset, clk_en, gsc, done;
	logic           en_a, ssr_a, en_b, ssr_b, co_a, co_b;
	logic           output_pipe_clock_enable_a, output_pipe_clock_enable_b, chain_a, chain_b;
	logic [3:0]     we_a, pi_a, po_a, we_b, pi_b, po_b;
	logic [14:0]    addr_a, addr_b;
	logic [31:0]    di_a, do_a, di_b, do_b;
	logic [16383:0] mem;
	logic [2047:0]  par;
	logic [31:0]    seed;
	int             err_total, tests_run;
	int             ia[7] = '{0, 7, 248, 448, 511, 300, 63};
	int             ib[4] = '{0, 496, 1023, 17};
	wire [35:0]     out_a = {po_a, do_a};
	wire [17:0]     out_b = {po_b[1:0], do_b[15:0]};

	// Free-running system clock
	always #20 clk_sys = ~clk_sys;

	dpr_fabric #(.SHIFT(SH_A), .PAIR18(PAIR_A)) fab_a (.i_clk_sys(clk_sys),
		.o_en(en_a), .o_we(we_a), .o_addr(addr_a), .o_data(di_a),
		.o_par(pi_a), .o_ssr(ssr_a));
	dpr_fabric #(.SHIFT(SH_B), .PAIR18(PAIR_B)) fab_b (.i_clk_sys(clk_sys),
		.o_en(en_b), .o_we(we_b), .o_addr(addr_b), .o_data(di_b),
		.o_par(pi_b), .o_ssr(ssr_b));

	// Port A wide and show-old, port B half width and hold
	dpr_ram_top #(.READ_WIDTH_A(WA), .WRITE_WIDTH_A(WA), .READ_WIDTH_B(WB),
		.WRITE_WIDTH_B(WB), .WRITE_MODE_A(dpr_pkg::WR_SHOW_OLD),
		.WRITE_MODE_B(dpr_pkg::WR_HOLD), .OUT_INIT_VALUE_A(INIT_A),
		.OUT_INIT_VALUE_B(INIT_B), .SYNC_CLEAR_VALUE_A(CLEAR_A),
		.CONTENT_INIT_VECTOR(CIV), .PARITY_INIT_VECTOR(PIV)) dut (
		.i_clk_sys(clk_sys), .i_reset(reset), .i_clk_en(clk_en),
		.i_global_set_clear(gsc), .i_en_a(en_a), .i_we_a(we_a),
		.i_addr_a(addr_a), .i_data_a(di_a), .i_parity_in_bus_a(pi_a),
		.i_sync_set_clear_a(ssr_a),
		.i_output_pipe_clock_enable_a(output_pipe_clock_enable_a), .i_chain_input_a(chain_a),
		.o_data_a(do_a), .o_parity_out_bus_a(po_a), .o_chain_output_a(co_a),
		.i_en_b(en_b), .i_we_b(we_b),
		.i_addr_b(addr_b), .i_data_b(di_b), .i_parity_in_bus_b(pi_b),
		.i_sync_set_clear_b(ssr_b),
		.i_output_pipe_clock_enable_b(output_pipe_clock_enable_b), .i_chain_input_b(chain_b),
		.o_data_b(do_b), .o_parity_out_bus_b(po_b), .o_chain_output_b(co_b),
		.o_init_done(done));

	// Repeatable xorshift source
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// Model words: parity above data, cells shared by both aspect ratios
	function automatic logic [35:0] exp_a(input int i);
		return {par[i*4 +: 4], mem[i*32 +: 32]};
	endfunction : exp_a

	function automatic logic [17:0] exp_b(input int i);
		return {par[i*2 +: 2], mem[i*16 +: 16]};
	endfunction : exp_b

	task automatic chk(input logic [35:0] got, input logic [35:0] exp,
		input string what);
		tests_run++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
			err_total++;
		end
	endtask : chk

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	task automatic rd_a(input int i);
		fab_a.op(1'b1, 4'h0, i, rnd(), 4'(rnd()), 1'b0);
		#1;
		chk(out_a, exp_a(i), "read a");
		chk({35'h0, co_a}, 36'h0, "chain a");
	endtask : rd_a

	task automatic rd_b(input int i);
		fab_b.op(1'b1, 4'h0, i, rnd(), 4'(rnd()), 1'b0);
		#1;
		chk({18'h0, out_b}, {18'h0, exp_b(i)}, "read b");
		chk({35'h0, co_b}, 36'h0, "chain b");
	endtask : rd_b

	// Partial byte writes; model merges only enabled lanes
	task automatic wr_a(input int i, input logic [3:0] we,
		input logic [31:0] d, input logic [3:0] p);
		logic [35:0] old;
		old = exp_a(i);
		fab_a.op(1'b1, we, i, d, p, 1'b0);
		#1;
		chk(out_a, old, "show old a");
		for (int l = 0; l < 4; l++)
			if (we[l]) begin
				mem[i*32 + l*8 +: 8] = d[l*8 +: 8];
				par[i*4 + l] = p[l];
			end
	endtask : wr_a

	// Hold mode keeps the last read word; no lane enabled means a plain read
	task automatic wr_b(input int i, input int held, input logic [1:0] we,
		input logic [15:0] d, input logic [1:0] p);
		logic [17:0] prev;
		prev = (we != 2'b00) ? exp_b(held) : exp_b(i);
		fab_b.op(1'b1, {2'b00, we}, i, {16'h0, d}, {2'b00, p}, 1'b0);
		#1;
		chk({18'h0, out_b}, {18'h0, prev}, "hold b");
		for (int l = 0; l < 2; l++)
			if (we[l]) begin
				mem[i*16 + l*8 +: 8] = d[l*8 +: 8];
				par[i*2 + l] = p[l];
			end
	endtask : wr_b

	// Cuts a hang short
	initial begin
		#4000000;
		$display("MISMATCH t=%0t watchdog expired", $time);
		err_total++;
		give_verdict();
	end

	// Main sequence
	initial begin
		int          idx, n;
		logic [35:0] w;
		clk_sys = 1'b0;
		reset = 1'b1;
		clk_en = 1'b1;
		gsc = 1'b0;
		{output_pipe_clock_enable_a, output_pipe_clock_enable_b, chain_a, chain_b} = 4'h0;
		seed = 32'h0000940F;
		err_total = 0;
		tests_run = 0;
		mem = CIV;
		par = PIV;
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		{output_pipe_clock_enable_a, output_pipe_clock_enable_b, chain_a, chain_b} <= 4'(rnd());
		#1;
		chk(out_a, INIT_A, "reset a");
		chk({18'h0, out_b}, {18'h0, INIT_B[17:0]}, "reset b");
		chk({35'h0, done}, 36'h0, "done in reset");
		n = 0;
		while (n < 200 && done !== 1'b1) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (n >= 200) begin
			$display("MISMATCH t=%0t load never ended", $time);
			err_total++;
			give_verdict();
		end
		chk(36'(n), 36'h48, "load edges");
		chk(out_a, INIT_A, "after load");
		$display("test reset done");
		foreach (ia[k]) rd_a(ia[k]);
		foreach (ib[k]) rd_b(ib[k]);
		$display("test contents done");
		for (int k = 0; k < 24; k++) begin
			idx = (k < 2) ? k * 511 : int'(rnd() & 32'h1FF);
			wr_a(idx, (k == 0) ? 4'hF : 4'(rnd()), rnd(), 4'(rnd()));
			rd_a(idx);
			rd_b(idx * 2);
		end
		$display("test write a done");
		for (int k = 0; k < 16; k++) begin
			idx = int'(rnd() & 32'h3FF);
			n = int'(rnd() & 32'h3FF);
			rd_b(n);
			wr_b(idx, n, 2'(rnd()), 16'(rnd()), 2'(rnd()));
			rd_b(idx);
			rd_a(idx / 2);
		end
		$display("test write b done");
		idx = 5;
		rd_a(idx);
		w = exp_a(idx);
		fab_a.op(1'b0, 4'hF, idx, ~w[31:0], ~w[35:32], 1'b0);
		#1;
		chk(out_a, w, "disabled");
		@(posedge clk_sys);
		clk_en <= 1'b0;
		fab_a.op(1'b1, 4'hF, idx, ~w[31:0], ~w[35:32], 1'b0);
		clk_en <= 1'b1;
		#1;
		chk(out_a, w, "frozen");
		rd_a(idx);
		fab_a.op(1'b0, 4'h0, idx, 32'h0, 4'h0, 1'b1);
		#1;
		chk(out_a, w, "clear off");
		fab_a.op(1'b1, 4'h0, idx, 32'h0, 4'h0, 1'b1);
		#1;
		chk(out_a, CLEAR_A, "clear");
		rd_a(idx);
		$display("test clear done");
		rd_b(3);
		@(posedge clk_sys);
		gsc <= 1'b1;
		@(posedge clk_sys);
		gsc <= 1'b0;
		#1;
		chk(out_a, INIT_A, "global a");
		chk({18'h0, out_b}, {18'h0, INIT_B[17:0]}, "global b");
		rd_a(idx);
		rd_b(3);
		$display("test global clear done");
		give_verdict();
	end
endmodule : tb
